// *** core/tilt_switched_output_logic.sv ***
// Switched relay output driven by tilt angle comparisons.
// Assumes parameter access strobes and angles synchronous to mclk.
//
// Overview of operation
// - Enable 0 keeps the relay off; 1 lets the comparison logic drive it.
// - Comparisons use a settable angle hysteresis, 0 to 45000 millidegrees.
// - A condition turning true waits 0 to 20000 ms before the output changes.
// - A condition turning false waits its own 0 to 20000 ms before release.
// - Axis results merge: 0 first axis only, 1 AND, 2 OR.
// - Each axis picks its angle: 0 yaw, 1 pitch, 2 roll.
// - Each axis merges its two conditions: 0 first only, 1 AND, 2 OR.
// - Thresholds are signed millidegrees limited to plus or minus 180000.
// - Compare select: 0 off, 1 true below threshold, 2 true above.
// - Invert 1 reverses the relay sense after the first switching (not the initial state), 0 keeps it normal.
`timescale 1ns/1ns
`default_nettype none
module tilt_switched_output_logic #(
  parameter int unsigned TICK_CYCLES = tilt_relay_pkg::MS_CYCLES
) (
  input  wire logic                              mclk,
  input  wire logic                              rst,
  input  wire logic [31:0]                       yaw_angle,
  input  wire logic [31:0]                       pitch_angle,
  input  wire logic [31:0]                       roll_angle,
  input  wire logic [tilt_relay_pkg::DID_W-1:0]  param_did,
  input  wire logic [tilt_relay_pkg::DATA_W-1:0] param_wdata,
  input  wire logic                              param_wr,
  input  wire logic                              param_rd,
  output logic [tilt_relay_pkg::DATA_W-1:0]      param_rdata,
  output logic                                   param_rvalid,
  output logic                                   param_err,
  output logic                                   relay_b_out
);
  import tilt_relay_pkg::*;

  typedef struct packed {
    logic [OUT1_SLOTS-1:0][31:0] regs;
    logic [31:0]                 out0_release_b;
    logic [31:0]                 rdata;
    logic                        rvalid;
    logic                        err;
    logic                        relay;
  } top_s;

  top_s state_reg;
  top_s state_next;

  logic [1:0] axis_result;
  logic       combined;
  logic       delayed_active;
  logic       delayed_started;

  ////////////////////////////////////////////////////////////////////////
  // Write limiting

  function automatic logic [31:0] limit_unsigned(input logic [31:0] d, input logic [31:0] max);
    return (d > max) ? max : d;
  endfunction

  function automatic logic [31:0] limit_angle(input logic [31:0] d);
    logic signed [31:0] v;
    logic signed [31:0] hi;
    v  = $signed(d);
    hi = $signed(ANGLE_MAX);
    if (v > hi) begin
      return ANGLE_MAX;
    end else if (v < -hi) begin
      return 32'(-hi);
    end
    return d;
  endfunction

  // Out-of-range writes saturate instead of being refused
  function automatic logic [31:0] limit_slot(input int unsigned s, input logic [31:0] d);
    if (s == slot(OFF_OUT1_AXIS0_COND0_ANGLE) || s == slot(OFF_OUT1_AXIS0_COND1_ANGLE) ||
        s == slot(OFF_OUT1_AXIS1_COND0_ANGLE) || s == slot(OFF_OUT1_AXIS1_COND1_ANGLE)) begin
      return limit_angle(d);
    end else if (s == slot(OFF_OUT1_HYSTERESIS)) begin
      return limit_unsigned(d, HYST_MAX);
    end else if (s == slot(OFF_OUT1_ASSERT_DELAY) || s == slot(OFF_OUT1_RELEASE_DELAY) ||
                 s == slot(OFF_OUT1_ASSERT_DELAY_B) || s == slot(OFF_OUT1_RELEASE_DELAY_B)) begin
      return limit_unsigned(d, DELAY_MAX);
    end else if (s == slot(OFF_OUT1_ENABLE) || s == slot(OFF_OUT1_INITIAL_STATE) ||
                 s == slot(OFF_OUT1_INVERT)) begin
      return limit_unsigned(d, FLAG_MAX);
    end
    return limit_unsigned(d, SEL_MAX);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Parameter access and relay state

  always_comb begin
    int unsigned s;
    logic [31:0] status;
    logic        enable;
    logic        init_on;
    logic        invert;
    s       = slot(param_did);
    status  = '0;
    enable  = state_reg.regs[slot(OFF_OUT1_ENABLE)][0];
    init_on = state_reg.regs[slot(OFF_OUT1_INITIAL_STATE)][0];
    invert  = state_reg.regs[slot(OFF_OUT1_INVERT)][0];
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    state_next.err    = 1'b0;

    status[ST_RELAY]   = state_reg.relay;
    status[ST_ACTIVE]  = delayed_active;
    status[ST_STARTED] = delayed_started;
    status[ST_AXIS0]   = axis_result[0];
    status[ST_AXIS1]   = axis_result[1];

    if (param_wr) begin
      if (param_did == OFF_OUT0_RELEASE_DELAY_B) begin
        state_next.out0_release_b = limit_unsigned(param_wdata, DELAY_MAX);
      end else if (param_did >= OFF_OUT1_ENABLE && param_did <= OFF_OUT1_RELEASE_DELAY_B) begin
        state_next.regs[s] = limit_slot(s, param_wdata);
      end else begin
        // Status is read only; unknown identifiers are flagged
        state_next.err = 1'b1;
      end
    end else if (param_rd) begin
      state_next.rvalid = 1'b1;
      if (param_did == OFF_OUT0_RELEASE_DELAY_B) begin
        state_next.rdata = state_reg.out0_release_b;
      end else if (param_did >= OFF_OUT1_ENABLE && param_did <= OFF_OUT1_RELEASE_DELAY_B) begin
        state_next.rdata = state_reg.regs[s];
      end else if (param_did == OFF_OUT1_STATUS) begin
        state_next.rdata = status;
      end else begin
        state_next.rdata = '0;
        state_next.err   = 1'b1;
      end
    end

    if (!enable) begin
      state_next.relay = 1'b0;
    end else if (!delayed_started) begin
      state_next.relay = init_on;
    end else begin
      state_next.relay = delayed_active ^ invert;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= '0;
      for (int i = 0; i < OUT1_SLOTS; i++) begin
        state_reg.regs[i] <= REG_RESET;
      end
      state_reg.out0_release_b <= REG_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Axis evaluation

  axis_cfg_if axis_bus [2] ();

  logic [31:0] relay_b_angle_hysteresis;
  assign relay_b_angle_hysteresis = state_reg.regs[slot(OFF_OUT1_HYSTERESIS)];

  generate
    for (genvar g = 0; g < 2; g++) begin : gen_axis
      localparam int unsigned BASE = slot(OFF_OUT1_AXIS0_SOURCE) + g * AXIS_STRIDE;
      localparam int unsigned O_CMB = slot(OFF_OUT1_AXIS0_COND_COMBINE) - slot(OFF_OUT1_AXIS0_SOURCE);
      localparam int unsigned O_A0  = slot(OFF_OUT1_AXIS0_COND0_ANGLE) - slot(OFF_OUT1_AXIS0_SOURCE);
      localparam int unsigned O_C0  = slot(OFF_OUT1_AXIS0_COND0_COMPARE) - slot(OFF_OUT1_AXIS0_SOURCE);
      localparam int unsigned O_A1  = slot(OFF_OUT1_AXIS0_COND1_ANGLE) - slot(OFF_OUT1_AXIS0_SOURCE);
      localparam int unsigned O_C1  = slot(OFF_OUT1_AXIS0_COND1_COMPARE) - slot(OFF_OUT1_AXIS0_SOURCE);

      assign axis_bus[g].source       = source_e'(state_reg.regs[BASE][1:0]);
      assign axis_bus[g].cond_combine = combine_e'(state_reg.regs[BASE + O_CMB][1:0]);
      assign axis_bus[g].threshold[0] = state_reg.regs[BASE + O_A0];
      assign axis_bus[g].compare[0]   = compare_e'(state_reg.regs[BASE + O_C0][1:0]);
      assign axis_bus[g].threshold[1] = state_reg.regs[BASE + O_A1];
      assign axis_bus[g].compare[1]   = compare_e'(state_reg.regs[BASE + O_C1][1:0]);
      assign axis_bus[g].hysteresis   = relay_b_angle_hysteresis;
      assign axis_result[g]           = axis_bus[g].result;

      axis_eval u_axis (
        .mclk        (mclk),
        .rst         (rst),
        .yaw_angle   (yaw_angle),
        .pitch_angle (pitch_angle),
        .roll_angle  (roll_angle),
        .cfg         (axis_bus[g])
      );
    end
  endgenerate

  always_comb begin
    case (combine_e'(state_reg.regs[slot(OFF_OUT1_AXIS_COMBINE)][1:0]))
      COMB_AND: combined = axis_result[0] & axis_result[1];
      COMB_OR:  combined = axis_result[0] | axis_result[1];
      default:  combined = axis_result[0];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Switching delays

  relay_delay #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_delay (
    .mclk       (mclk),
    .rst        (rst),
    .enable     (state_reg.regs[slot(OFF_OUT1_ENABLE)][0]),
    .init_state (state_reg.regs[slot(OFF_OUT1_INITIAL_STATE)][0]),
    .cond       (combined),
    .assert_ms  (state_reg.regs[slot(OFF_OUT1_ASSERT_DELAY)][DELAY_W-1:0]),
    .release_ms (state_reg.regs[slot(OFF_OUT1_RELEASE_DELAY)][DELAY_W-1:0]),
    .active     (delayed_active),
    .started    (delayed_started)
  );

  assign param_rdata  = state_reg.rdata;
  assign param_rvalid = state_reg.rvalid;
  assign param_err    = state_reg.err;
  assign relay_b_out  = state_reg.relay;
endmodule
`default_nettype wire

// *** inc/tilt_relay_pkg.sv ***
// Shared constants for the tilt switched relay output logic.
// Assumes one 50 MHz clock and parameter access by 16-bit identifier.
package tilt_relay_pkg;

  localparam int unsigned DID_W  = 16;
  localparam int unsigned DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////
  // Parameter identifiers
  localparam logic [15:0] OFF_OUT0_RELEASE_DELAY_B     = 16'hf264;
  localparam logic [15:0] OFF_OUT1_ENABLE              = 16'hf270;
  localparam logic [15:0] OFF_OUT1_HYSTERESIS          = 16'hf271;
  localparam logic [15:0] OFF_OUT1_ASSERT_DELAY        = 16'hf272;
  localparam logic [15:0] OFF_OUT1_RELEASE_DELAY       = 16'hf273;
  localparam logic [15:0] OFF_OUT1_AXIS_COMBINE        = 16'hf274;
  localparam logic [15:0] OFF_OUT1_AXIS0_SOURCE        = 16'hf275;
  localparam logic [15:0] OFF_OUT1_AXIS0_COND_COMBINE  = 16'hf276;
  localparam logic [15:0] OFF_OUT1_AXIS0_COND0_ANGLE   = 16'hf277;
  localparam logic [15:0] OFF_OUT1_AXIS0_COND0_COMPARE = 16'hf278;
  localparam logic [15:0] OFF_OUT1_AXIS0_COND1_ANGLE   = 16'hf279;
  localparam logic [15:0] OFF_OUT1_AXIS0_COND1_COMPARE = 16'hf27a;
  localparam logic [15:0] OFF_OUT1_AXIS1_SOURCE        = 16'hf27b;
  localparam logic [15:0] OFF_OUT1_AXIS1_COND_COMBINE  = 16'hf27c;
  localparam logic [15:0] OFF_OUT1_AXIS1_COND0_ANGLE   = 16'hf27d;
  localparam logic [15:0] OFF_OUT1_AXIS1_COND0_COMPARE = 16'hf27e;
  localparam logic [15:0] OFF_OUT1_AXIS1_COND1_ANGLE   = 16'hf27f;
  localparam logic [15:0] OFF_OUT1_AXIS1_COND1_COMPARE = 16'hf280;
  localparam logic [15:0] OFF_OUT1_INITIAL_STATE       = 16'hf281;
  localparam logic [15:0] OFF_OUT1_INVERT              = 16'hf282;
  localparam logic [15:0] OFF_OUT1_ASSERT_DELAY_B      = 16'hf283;
  localparam logic [15:0] OFF_OUT1_RELEASE_DELAY_B     = 16'hf284;
  localparam logic [15:0] OFF_OUT1_STATUS              = 16'hf28f;

  localparam int unsigned OUT1_SLOTS  = 21;
  localparam int unsigned AXIS_STRIDE = 6;
  localparam logic [31:0] REG_RESET   = 32'h0000_0000;

  // Status word bit positions
  localparam int unsigned ST_RELAY   = 0;
  localparam int unsigned ST_ACTIVE  = 1;
  localparam int unsigned ST_STARTED = 2;
  localparam int unsigned ST_AXIS0   = 3;
  localparam int unsigned ST_AXIS1   = 4;

  ////////////////////////////////////////////////////////////////////////
  // Ranges, in millidegrees and milliseconds
  localparam logic [31:0] HYST_MAX   = 32'h0000_afc8;
  localparam logic [31:0] DELAY_MAX  = 32'h0000_4e20;
  localparam logic [31:0] ANGLE_MAX  = 32'h0002_bf20;
  localparam logic [31:0] SEL_MAX    = 32'h0000_0002;
  localparam logic [31:0] FLAG_MAX   = 32'h0000_0001;
  localparam int unsigned DELAY_W    = 15;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    SRC_YAW   = 2'b00,
    SRC_PITCH = 2'b01,
    SRC_ROLL  = 2'b10
  } source_e;

  typedef enum logic [1:0] {
    COMB_SINGLE = 2'b00,
    COMB_AND    = 2'b01,
    COMB_OR     = 2'b10
  } combine_e;

  typedef enum logic [1:0] {
    CMP_NONE = 2'b00,
    CMP_LT   = 2'b01,
    CMP_GT   = 2'b10
  } compare_e;

  function automatic int unsigned slot(input logic [15:0] off);
    return int'(off - OFF_OUT1_ENABLE);
  endfunction

endpackage

// *** inc/axis_cfg_if.sv ***
// Configuration and result of one compared axis.
// Assumes the owner drives settings and reads back the axis result.
`timescale 1ns/1ns
`default_nettype none
interface axis_cfg_if;
  import tilt_relay_pkg::*;
  source_e          source;
  combine_e         cond_combine;
  logic [1:0][31:0] threshold;
  compare_e [1:0]   compare;
  logic [31:0]      hysteresis;
  logic             result;

  modport owner (output source, cond_combine, threshold, compare, hysteresis, input result);
  modport eval  (input source, cond_combine, threshold, compare, hysteresis, output result);
endinterface
`default_nettype wire

// *** core/axis_eval.sv ***
// One axis: source select, two hysteretic conditions, merge.
// Assumes angles are signed millidegrees, synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
module axis_eval (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [31:0] yaw_angle,
  input  wire logic [31:0] pitch_angle,
  input  wire logic [31:0] roll_angle,
  axis_cfg_if.eval         cfg
);
  import tilt_relay_pkg::*;

  typedef struct packed {
    logic [1:0] cond;
    logic       result;
  } axis_s;

  axis_s state_reg;
  axis_s state_next;

  always_comb begin
    logic signed [31:0] ang;
    logic signed [31:0] thr;
    logic signed [31:0] hys;
    ang = $signed(yaw_angle);
    thr = 32'sh0;
    hys = $signed(cfg.hysteresis);
    state_next = state_reg;
    case (cfg.source)
      SRC_PITCH: ang = $signed(pitch_angle);
      SRC_ROLL:  ang = $signed(roll_angle);
      default:   ang = $signed(yaw_angle);
    endcase
    for (int i = 0; i < 2; i++) begin
      thr = $signed(cfg.threshold[i]);
      case (cfg.compare[i])
        CMP_LT:  state_next.cond[i] = state_reg.cond[i] ? (ang < thr + hys) : (ang < thr);
        CMP_GT:  state_next.cond[i] = state_reg.cond[i] ? (ang > thr - hys) : (ang > thr);
        default: state_next.cond[i] = 1'b0;
      endcase
    end
    case (cfg.cond_combine)
      COMB_AND: state_next.result = state_next.cond[0] & state_next.cond[1];
      COMB_OR:  state_next.result = state_next.cond[0] | state_next.cond[1];
      default:  state_next.result = state_next.cond[0];
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cfg.result = state_reg.result;
endmodule
`default_nettype wire

// *** core/relay_delay.sv ***
// Assert and release delays in whole milliseconds.
// Assumes the condition input is already registered.
`timescale 1ns/1ns
`default_nettype none
module relay_delay #(
  parameter int unsigned TICK_CYCLES = tilt_relay_pkg::MS_CYCLES
) (
  input  wire logic                               mclk,
  input  wire logic                               rst,
  input  wire logic                               enable,
  input  wire logic                               init_state,
  input  wire logic                               cond,
  input  wire logic [tilt_relay_pkg::DELAY_W-1:0] assert_ms,
  input  wire logic [tilt_relay_pkg::DELAY_W-1:0] release_ms,
  output logic                                    active,
  output logic                                    started
);
  import tilt_relay_pkg::*;

  typedef struct packed {
    logic               active;
    logic               started;
    logic [31:0]        pre;
    logic [DELAY_W-1:0] ms;
  } delay_s;

  delay_s state_reg;
  delay_s state_next;

  always_comb begin
    logic [DELAY_W-1:0] limit;
    limit = cond ? assert_ms : release_ms;
    state_next = state_reg;
    if (!enable) begin
      state_next = '0;
      state_next.active = init_state;
    end else if (cond == state_reg.active) begin
      // Restart so every delay is measured in full
      state_next.pre = '0;
      state_next.ms  = '0;
    end else if (state_reg.ms >= limit) begin
      state_next.active  = cond;
      state_next.started = 1'b1;
      state_next.pre     = '0;
      state_next.ms      = '0;
    end else if (state_reg.pre == TICK_CYCLES - 1) begin
      state_next.pre = '0;
      state_next.ms  = DELAY_W'(state_reg.ms + 1'b1);
    end else begin
      state_next.pre = state_reg.pre + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign active  = state_reg.active;
  assign started = state_reg.started;
endmodule
`default_nettype wire

// *** sim/tilt_angle_model.sv ***
// Angle source standing in for the sensor front end.
// Assumes the bench pulses load for one cycle with all three angles.
`timescale 1ns/1ns
`default_nettype none
module tilt_angle_model (
  input  wire logic        mclk,
  input  wire logic        load,
  input  wire logic [31:0] yaw_cmd,
  input  wire logic [31:0] pitch_cmd,
  input  wire logic [31:0] roll_cmd,
  output logic      [31:0] yaw_angle,
  output logic      [31:0] pitch_angle,
  output logic      [31:0] roll_angle
);
  initial begin
    yaw_angle = 32'h0;
    pitch_angle = 32'h0;
    roll_angle = 32'h0;
  end
  // separate yaw pitch roll
  // Updated by NBA on the edge so the design sees a clean step
  always @(posedge mclk) begin
    if (load) begin
      yaw_angle <= yaw_cmd;
      pitch_angle <= pitch_cmd;
      roll_angle <= roll_cmd;
    end
  end
endmodule
`default_nettype wire

// *** sim/tilt_switched_output_logic_monitor.sv ***
// Port checker for the tilt relay output block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module tilt_switched_output_logic_monitor
  import tilt_relay_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [15:0] param_did,
  input wire logic [31:0] param_wdata,
  input wire logic        param_wr,
  input wire logic        param_rd,
  input wire logic [31:0] param_rdata,
  input wire logic        param_rvalid,
  input wire logic        param_err,
  input wire logic        relay_b_out
);
  logic en_reg;
  logic rd_take;
  logic ok_did;
  assign rd_take = param_rd && !param_wr;
  assign ok_did = (param_did == OFF_OUT0_RELEASE_DELAY_B) || (param_did == OFF_OUT1_STATUS)
                  || (param_did >= OFF_OUT1_ENABLE && param_did <= OFF_OUT1_RELEASE_DELAY_B);
  // Shadow of the enable, saturating writes count as on
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_reg <= 1'b0;
    end else if (param_wr && param_did == OFF_OUT1_ENABLE) begin
      en_reg <= (param_wdata != 32'h0);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  AST_READ_ANSWER: assert property (rd_take |=> param_rvalid)
    else $error("read strobe without rvalid");
  AST_RVALID_CAUSE: assert property (param_rvalid |-> $past(rd_take))
    else $error("rvalid without read");
  AST_QUIET: assert property (!param_wr && !param_rd |=> !param_rvalid && !param_err)
    else $error("pulse without strobe");
  AST_UNMAPPED_READ: assert property (rd_take && !ok_did |=> param_err && param_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_MAPPED_READ: assert property (rd_take && ok_did |=> !param_err)
    else $error("mapped read flagged");
  AST_STATUS_WRITE: assert property (param_wr && param_did == OFF_OUT1_STATUS |=> param_err)
    else $error("status write accepted");
  AST_HYST_SAT: assert property ((param_wr && param_did == OFF_OUT1_HYSTERESIS && param_wdata > HYST_MAX)
    ##1 (rd_take && param_did == OFF_OUT1_HYSTERESIS) |=> param_rdata == HYST_MAX)
    else $error("hysteresis not limited");
  AST_RDATA_HOLD: assert property (!param_rvalid |-> $stable(param_rdata))
    else $error("rdata moved without read");
  AST_DISABLED_OFF: assert property (!en_reg && !$past(en_reg) && !$past(en_reg, 2) && !$past(en_reg, 4)
    |-> !relay_b_out)
    else $error("relay on while disabled");
  AST_RESET_CLEAN: assert property ($fell(rst) |-> !relay_b_out && !param_rvalid && !param_err)
    else $error("outputs not clear after reset");
endmodule
bind tilt_switched_output_logic tilt_switched_output_logic_monitor tilt_switched_output_logic_monitor_i (
  .mclk(mclk), .rst(rst), .param_did(param_did), .param_wdata(param_wdata), .param_wr(param_wr),
  .param_rd(param_rd), .param_rdata(param_rdata), .param_rvalid(param_rvalid), .param_err(param_err),
  .relay_b_out(relay_b_out));
`default_nettype wire

// *** sim/tilt_switched_output_logic_tb.sv ***
// Self-checking bench for the tilt relay output block.
// Assumes a 1 ms tick of 10 cycles so delays stay short.
`timescale 1ns/1ns
`default_nettype none
module tilt_switched_output_logic_tb;
  import tilt_relay_pkg::*;
  localparam int TICK = 10;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] param_did = 16'h0;
  logic [31:0] param_wdata = 32'h0;
  logic        param_wr = 1'b0;
  logic        param_rd = 1'b0;
  logic [31:0] param_rdata;
  logic        param_rvalid;
  logic        param_err;
  logic        relay_b_out;
  logic        load = 1'b0;
  logic [31:0] yaw_cmd = 32'h0;
  logic [31:0] pitch_cmd = 32'h0;
  logic [31:0] roll_cmd = 32'h0;
  logic [31:0] yaw_angle;
  logic [31:0] pitch_angle;
  logic [31:0] roll_angle;
  int          errors = 0;
  int          tests_run = 0;
  logic [15:0] sd [8] = '{OFF_OUT1_HYSTERESIS, OFF_OUT1_ASSERT_DELAY, OFF_OUT1_RELEASE_DELAY,
    OFF_OUT1_AXIS0_COND0_ANGLE, OFF_OUT1_AXIS1_COND1_ANGLE, OFF_OUT1_AXIS1_COND0_COMPARE,
    OFF_OUT1_AXIS_COMBINE, OFF_OUT1_INVERT};
  logic [31:0] sw [8] = '{32'h0001_0000, 32'h0000_ffff, 32'h0000_ffff, 32'hfffc_f2c0, 32'h0003_0d40,
    32'h5, 32'h3, 32'h9};
  logic [31:0] se [8] = '{32'h0000_afc8, 32'h0000_4e20, 32'h0000_4e20, 32'hfffd_40e0, 32'h0002_bf20,
    32'h2, 32'h2, 32'h1};

  always #10 mclk = ~mclk;

  tilt_angle_model tilt_angle_model_i (.mclk(mclk), .load(load), .yaw_cmd(yaw_cmd), .pitch_cmd(pitch_cmd),
    .roll_cmd(roll_cmd), .yaw_angle(yaw_angle), .pitch_angle(pitch_angle), .roll_angle(roll_angle));
  tilt_switched_output_logic #(.TICK_CYCLES(TICK)) tilt_switched_output_logic_i (.mclk(mclk), .rst(rst),
    .yaw_angle(yaw_angle), .pitch_angle(pitch_angle), .roll_angle(roll_angle), .param_did(param_did),
    .param_wdata(param_wdata), .param_wr(param_wr), .param_rd(param_rd), .param_rdata(param_rdata),
    .param_rvalid(param_rvalid), .param_err(param_err), .relay_b_out(relay_b_out));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Called at a falling edge; each task leaves the strobes for the next one
  task automatic put(input logic [15:0] did, input logic [31:0] data);
    param_wr = 1'b1;
    param_rd = 1'b0;
    param_did = did;
    param_wdata = data;
    @(negedge mclk);
  endtask
  task automatic get(input logic [15:0] did, output logic [31:0] data);
    param_wr = 1'b0;
    param_rd = 1'b1;
    param_did = did;
    @(negedge mclk);
    data = (param_rvalid === 1'b1) ? param_rdata : 32'hxxxx_xxxx;
  endtask
  task automatic do_reset();
    param_wr = 1'b0;
    param_rd = 1'b0;
    rst = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
  endtask
  task automatic set_angles(input logic [31:0] y, input logic [31:0] p, input logic [31:0] r);
    param_wr = 1'b0;
    param_rd = 1'b0;
    yaw_cmd = y;
    pitch_cmd = p;
    roll_cmd = r;
    load = 1'b1;
    @(negedge mclk);
    load = 1'b0;
    @(negedge mclk);
  endtask
  // Wait for level w within limit cycles, then require level h for hold cycles
  task automatic relay_seq(input logic w, input int limit, input logic h, input int hold);
    int   n;
    logic held;
    param_wr = 1'b0;
    param_rd = 1'b0;
    n = 0;
    held = 1'b1;
    while (relay_b_out !== w && n < limit) begin
      @(negedge mclk);
      n++;
    end
    check({31'h0, relay_b_out}, {31'h0, w});
    for (n = 0; n < hold; n++) begin
      @(negedge mclk);
      if (relay_b_out !== h) held = 1'b0;
    end
    check({31'h0, held}, 32'h1);
  endtask
  task automatic sel_loop(input logic [15:0] did, input logic [2:0] exp);
    for (int k = 0; k < 3; k++) begin
      put(did, k);
      relay_seq(exp[k], 10, exp[k], 5);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    $display("unexpected at %0t: run did not finish", $time);
    report_and_stop();
  end

  initial begin
    logic [31:0] d;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    for (int a = 0; a < 21; a++) begin
      get(OFF_OUT1_ENABLE + a[15:0], d);
      check(d, REG_RESET);
    end
    get(OFF_OUT0_RELEASE_DELAY_B, d);
    check(d, REG_RESET);
    put(OFF_OUT0_RELEASE_DELAY_B, 32'h0000_ffff);
    get(OFF_OUT0_RELEASE_DELAY_B, d);
    check(d, DELAY_MAX);
    get(16'hf265, d);
    check({d[30:0], param_err}, 32'h1);
    put(OFF_OUT1_STATUS, 32'h1);
    check({31'h0, param_err}, 32'h1);
    for (int a = 0; a < 8; a++) begin
      put(sd[a], sw[a]);
      get(sd[a], d);
      check(d, se[a]);
    end
    $display("test registers done");
    do_reset();
    put(OFF_OUT1_AXIS0_SOURCE, 32'h1);
    put(OFF_OUT1_AXIS0_COND0_COMPARE, 32'h2);
    put(OFF_OUT1_AXIS0_COND0_ANGLE, 32'd1000);
    put(OFF_OUT1_HYSTERESIS, 32'd1000);
    put(OFF_OUT1_ENABLE, 32'h1);
    set_angles(32'h0, 32'd2000, 32'h0);
    relay_seq(1'b1, 10, 1'b1, 3);
    set_angles(32'h0, 32'd500, 32'h0);
    relay_seq(1'b1, 0, 1'b1, 10);
    set_angles(32'h0, -32'sd100, 32'h0);
    relay_seq(1'b0, 10, 1'b0, 3);
    put(OFF_OUT1_AXIS0_COND0_ANGLE, 32'h0);
    put(OFF_OUT1_HYSTERESIS, 32'h0);
    for (int s = 0; s < 3; s++) begin
      put(OFF_OUT1_AXIS0_SOURCE, s);
      set_angles(s == 0 ? -32'sd2000 : 32'sd2000, s == 1 ? -32'sd2000 : 32'sd2000, s == 2 ? -32'sd2000 : 32'sd2000);
      relay_seq(1'b0, 10, 1'b0, 6);
      set_angles(s == 0 ? 32'sd2000 : -32'sd2000, s == 1 ? 32'sd2000 : -32'sd2000, s == 2 ? 32'sd2000 : -32'sd2000);
      relay_seq(1'b1, 10, 1'b1, 3);
    end
    put(OFF_OUT1_AXIS0_SOURCE, 32'h1);
    set_angles(32'h0, -32'sd500, -32'sd1000);
    sel_loop(OFF_OUT1_AXIS0_COND0_COMPARE, 3'b010);
    $display("test compare done");
    put(OFF_OUT1_AXIS0_COND1_ANGLE, 32'd5000);
    put(OFF_OUT1_AXIS0_COND1_COMPARE, 32'h2);
    set_angles(32'h0, 32'd1000, -32'sd1000);
    sel_loop(OFF_OUT1_AXIS0_COND_COMBINE, 3'b101);
    put(OFF_OUT1_AXIS0_COND_COMBINE, 32'h0);
    put(OFF_OUT1_AXIS1_SOURCE, 32'h2);
    put(OFF_OUT1_AXIS1_COND0_COMPARE, 32'h2);
    sel_loop(OFF_OUT1_AXIS_COMBINE, 3'b101);
    $display("test combine done");
    put(OFF_OUT1_INVERT, 32'h1);
    relay_seq(1'b0, 10, 1'b0, 5);
    put(OFF_OUT1_INVERT, 32'h0);
    relay_seq(1'b1, 10, 1'b1, 5);
    // Status: relay, active, started and axis 0 set, axis 1 clear
    get(OFF_OUT1_STATUS, d);
    check(d, 32'h0000_000f);
    put(OFF_OUT1_ASSERT_DELAY, 32'h2);
    put(OFF_OUT1_RELEASE_DELAY, 32'h3);
    set_angles(32'h0, -32'sd1000, -32'sd1000);
    relay_seq(1'b1, 0, 1'b1, 3 * TICK - 5);
    relay_seq(1'b0, 15, 1'b0, 2);
    set_angles(32'h0, 32'd1000, -32'sd1000);
    relay_seq(1'b0, 0, 1'b0, 2 * TICK - 5);
    relay_seq(1'b1, 15, 1'b1, 2);
    put(OFF_OUT1_ENABLE, 32'h0);
    relay_seq(1'b0, 10, 1'b0, 8);
    $display("test delay and enable done");
    do_reset();
    put(OFF_OUT1_INITIAL_STATE, 32'h1);
    put(OFF_OUT1_RELEASE_DELAY, 32'h5);
    put(OFF_OUT1_ENABLE, 32'h1);
    relay_seq(1'b1, 5, 1'b1, 30);
    relay_seq(1'b0, 40, 1'b0, 2);
    $display("test initial state done");
    report_and_stop();
  end
endmodule
`default_nettype wire
